// File: design/aer_pkg.sv
// Constants for the root port error reporting register set.
// Assumes byte offsets of 32-bit configuration registers on word boundaries.
package aer_pkg;

    // ----------------------------------------------------------------
    // Register byte offsets
    // ----------------------------------------------------------------
    localparam logic [11:0] UNCOR_STATUS_OFF = 12'h154;
    localparam logic [11:0] UNCOR_MASK_OFF = 12'h158;
    localparam logic [11:0] UNCOR_SEVERITY_OFF = 12'h15C;
    localparam logic [11:0] COR_STATUS_OFF = 12'h160;
    localparam logic [11:0] COR_MASK_OFF = 12'h164;
    localparam logic [11:0] ADV_CONTROL_OFF = 12'h168;
    localparam logic [11:0] HEADER_LOG0_OFF = 12'h16C;
    localparam logic [11:0] HEADER_LOG1_OFF = 12'h170;
    localparam logic [11:0] HEADER_LOG2_OFF = 12'h174;
    localparam logic [11:0] HEADER_LOG3_OFF = 12'h178;
    localparam logic [11:0] ROOT_COMMAND_OFF = 12'h17C;
    localparam logic [11:0] ROOT_STATUS_OFF = 12'h180;
    localparam logic [11:0] SOURCE_ID_OFF = 12'h184;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] UNCOR_MASK_RESET = 32'h00000000;
    localparam logic [31:0] UNCOR_SEVERITY_RESET = 32'h00062030;
    localparam logic [31:0] COR_MASK_RESET = 32'h00002000;
    localparam logic [2:0] ROOT_COMMAND_RESET = 3'h0;
    localparam logic [4:0] ERR_VECTOR_NUMBER = 5'h00;

    // ----------------------------------------------------------------
    // Field layouts
    // ----------------------------------------------------------------
    // Uncorrectable classes: 20 unsupported request, 18 malformed, 16 unexpected
    // completion, 14 completion timeout, 12 poisoned, 4 link protocol.
    localparam logic [31:0] UNCOR_RW_BITS = 32'h00155010;
    localparam logic [31:0] UNCOR_HDR_BITS = 32'h00151000;
    localparam int E2E_CRC_BIT = 19;
    localparam int UR_BIT = 20;
    localparam int MALFORMED_BIT = 18;
    localparam int UNEXP_CPL_BIT = 16;
    localparam int CPL_TIMEOUT_BIT = 14;
    localparam int POISONED_BIT = 12;
    localparam int LINK_PROTOCOL_BIT = 4;
    // Correctable: 13 advisory, 12 replay timeout, 8 rollover, 7 bad DLLP, 6 bad TLP.
    localparam logic [31:0] COR_RW_BITS = 32'h000031C0;
    localparam int ADVISORY_BIT = 13;
    localparam int REPLAY_TIMEOUT_BIT = 12;
    localparam int ROLLOVER_BIT = 8;
    localparam int BAD_LINK_PKT_BIT = 7;
    localparam int BAD_TRANS_PKT_BIT = 6;
    localparam int RECEIVER_BIT = 0;
    localparam int E2E_CHECK_EN_BIT = 8;
    localparam int VECTOR_LSB = 27;
    // Root status bit positions.
    localparam int RS_COR = 0;
    localparam int RS_MULT_COR = 1;
    localparam int RS_UNCOR = 2;
    localparam int RS_MULT_UNCOR = 3;
    localparam int RS_FIRST_FATAL = 4;
    localparam int RS_NONFATAL = 5;
    localparam int RS_FATAL = 6;
    localparam logic [6:0] ROOT_STATUS_RESET = 7'h00;

endpackage

// File: design/aer_regs.sv
// Root port advanced error reporting registers with their event logic.
// Assumes configuration accesses, error events and messages all arrive on
// the same clock as single-cycle strobes from the link and transaction layers.
`timescale 1ns/1ps

// How it works
// (RQ1) Uncorrectable mask bits 20,18,16,14,12,4 are writable; set bit suppresses reporting.
// (RQ2) Bit 19 mask and severity writable only while end-to-end check enable is one.
// (RQ3) Writable severity bits mark their error fatal when one, non-fatal when zero.
// (RQ4) Non-fatal unsupported request or unexpected completion sets advisory bit 13.
// (RQ5) Replay rollover with retraining sets correctable status bit 8.
// (RQ6) Link CRC error sets bad link packet bit 7, write one clears.
// (RQ7) Bad sequence number or link CRC error sets bit 6, write one clears.
// (RQ8) Decode or disparity error sets read-only receiver error bit 0.
// (RQ9) Correctable mask bits 13,12,8,7,6 writable; receiver mask bit 0 read-only.
// (RQ10) End-to-end CRC capability and enable bits of control register read zero.
// (RQ11) Five-bit first error pointer holds position of first uncorrectable error.
// (RQ12) Four header log words capture the faulty packet header, byte 0 uppermost.
// (RQ13) Root command bits enable interrupts for fatal, non-fatal, correctable messages.
// (RQ14) Fatal and non-fatal messages set root status bits 6 and 5.
// (RQ15) Bit 4 set when the first uncorrectable message is fatal.
// (RQ16) Uncorrectable message sets bit 2, or bit 3 when bit 2 already set.
// (RQ17) Correctable message sets bit 0, or bit 1 when bit 0 already set.
// (RQ18) Uncorrectable source ID loads only while root status bit 2 is clear.
// (RQ19) Correctable source ID loads only while root status bit 0 is clear.
// (RQ20) Root status bits 31 to 27 hold the read-only interrupt vector number.
// (RQ21) Malformed packet sets its status bit and logs the packet header.
// (RQ22) Write one clears status bits except correctable receiver bit 0, zero leaves them; reserved bits read zero.
module aer_regs (
    input wire logic clock,
    input wire logic rst,
    input wire logic cfg_write,
    input wire logic cfg_read,
    input wire logic [11:0] cfg_addr,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    output logic cfg_rvalid,
    input wire logic unsupported_request_err,
    input wire logic malformed_packet_err,
    input wire logic unexpected_completion_err,
    input wire logic completion_timeout_err,
    input wire logic poisoned_packet_err,
    input wire logic link_protocol_err,
    input wire logic [127:0] err_packet_header,
    input wire logic replay_timeout_err,
    input wire logic replay_rollover_err,
    input wire logic link_crc_err,
    input wire logic bad_sequence_err,
    input wire logic receiver_decode_err,
    input wire logic msg_cor,
    input wire logic msg_nonfatal,
    input wire logic msg_fatal,
    input wire logic [15:0] msg_requester_id,
    output logic report_fatal,
    output logic report_nonfatal,
    output logic report_correctable,
    output logic error_interrupt
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] uncor_status_q;
    logic [31:0] uncor_mask_q;
    logic [31:0] uncor_sev_q;
    logic [31:0] cor_status_q;
    logic [31:0] cor_mask_q;
    logic [4:0] first_error_position_q;
    logic [127:0] logged_packet_header_q;
    logic [2:0] root_command_q;
    logic [6:0] root_status_q;
    logic [15:0] uncorrectable_source_id_q;
    logic [15:0] correctable_source_id_q;
    logic e2e_crc_check_enable;
    logic [31:0] uncor_event;
    logic [31:0] cor_event;
    logic [31:0] uncor_new;
    logic [4:0] first_pos;
    logic [2:0] msg_level;
    logic [6:0] root_set;
    logic [6:0] root_clr;

    // Checking is not supported, so the enable is a constant zero.
    assign e2e_crc_check_enable = 1'b0; // RQ10

    // ----------------------------------------------------------------
    // Event collection
    // ----------------------------------------------------------------
    always_comb
    begin
        uncor_event = 32'h00000000;
        uncor_event[aer_pkg::UR_BIT] = unsupported_request_err;
        uncor_event[aer_pkg::MALFORMED_BIT] = malformed_packet_err; // RQ21
        uncor_event[aer_pkg::UNEXP_CPL_BIT] = unexpected_completion_err;
        uncor_event[aer_pkg::CPL_TIMEOUT_BIT] = completion_timeout_err;
        uncor_event[aer_pkg::POISONED_BIT] = poisoned_packet_err;
        uncor_event[aer_pkg::LINK_PROTOCOL_BIT] = link_protocol_err;
    end

    always_comb
    begin
        cor_event = 32'h00000000;
        cor_event[aer_pkg::ADVISORY_BIT] =
            (unsupported_request_err & ~uncor_sev_q[aer_pkg::UR_BIT]) |
            (unexpected_completion_err & ~uncor_sev_q[aer_pkg::UNEXP_CPL_BIT]); // RQ4
        cor_event[aer_pkg::REPLAY_TIMEOUT_BIT] = replay_timeout_err;
        cor_event[aer_pkg::ROLLOVER_BIT] = replay_rollover_err; // RQ5
        cor_event[aer_pkg::BAD_LINK_PKT_BIT] = link_crc_err; // RQ6
        cor_event[aer_pkg::BAD_TRANS_PKT_BIT] = bad_sequence_err | link_crc_err; // RQ7
        cor_event[aer_pkg::RECEIVER_BIT] = receiver_decode_err; // RQ8
    end

    // Unmasked uncorrectable errors; the highest position wins a tie.
    assign uncor_new = uncor_event & ~uncor_mask_q;

    always_comb
    begin
        first_pos = 5'h00;
        for (int i = 0; i < 32; i++)
        begin
            if (uncor_new[i])
            begin
                first_pos = 5'(i);
            end
        end
    end

    assign msg_level = {msg_fatal, msg_nonfatal, msg_cor};

    // ----------------------------------------------------------------
    // Uncorrectable mask, severity and status
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            uncor_mask_q <= aer_pkg::UNCOR_MASK_RESET;
        end
        else if (cfg_write && cfg_addr == aer_pkg::UNCOR_MASK_OFF)
        begin
            uncor_mask_q <= (uncor_mask_q & ~aer_pkg::UNCOR_RW_BITS) |
                (cfg_wdata & aer_pkg::UNCOR_RW_BITS); // RQ1
            if (e2e_crc_check_enable)
            begin
                uncor_mask_q[aer_pkg::E2E_CRC_BIT] <= cfg_wdata[aer_pkg::E2E_CRC_BIT]; // RQ2
            end
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            uncor_sev_q <= aer_pkg::UNCOR_SEVERITY_RESET;
        end
        else if (cfg_write && cfg_addr == aer_pkg::UNCOR_SEVERITY_OFF)
        begin
            uncor_sev_q <= (uncor_sev_q & ~aer_pkg::UNCOR_RW_BITS) |
                (cfg_wdata & aer_pkg::UNCOR_RW_BITS); // RQ3
            if (e2e_crc_check_enable)
            begin
                uncor_sev_q[aer_pkg::E2E_CRC_BIT] <= cfg_wdata[aer_pkg::E2E_CRC_BIT]; // RQ2
            end
        end
    end

    // A set arriving together with its clear wins, so no error is lost.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            uncor_status_q <= 32'h00000000;
        end
        else if (cfg_write && cfg_addr == aer_pkg::UNCOR_STATUS_OFF)
        begin
            uncor_status_q <= (uncor_status_q & ~(cfg_wdata & aer_pkg::UNCOR_RW_BITS)) |
                uncor_event; // RQ22
        end
        else
        begin
            uncor_status_q <= uncor_status_q | uncor_event; // RQ21
        end
    end

    // The pointer and header log freeze while any unmasked error is pending.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            first_error_position_q <= 5'h00;
            logged_packet_header_q <= 128'h0;
        end
        else if (|uncor_new && !(|(uncor_status_q & ~uncor_mask_q)))
        begin
            first_error_position_q <= first_pos; // RQ11
            if (|(uncor_new & aer_pkg::UNCOR_HDR_BITS))
            begin
                logged_packet_header_q <= err_packet_header; // RQ12
            end
        end
    end

    // ----------------------------------------------------------------
    // Correctable status and mask
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cor_status_q <= 32'h00000000;
        end
        else if (cfg_write && cfg_addr == aer_pkg::COR_STATUS_OFF)
        begin
            cor_status_q <= (cor_status_q & ~(cfg_wdata & aer_pkg::COR_RW_BITS)) |
                cor_event; // RQ22
        end
        else
        begin
            cor_status_q <= cor_status_q | cor_event;
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cor_mask_q <= aer_pkg::COR_MASK_RESET;
        end
        else if (cfg_write && cfg_addr == aer_pkg::COR_MASK_OFF)
        begin
            cor_mask_q <= (cor_mask_q & ~aer_pkg::COR_RW_BITS) |
                (cfg_wdata & aer_pkg::COR_RW_BITS); // RQ9
        end
    end

    // ----------------------------------------------------------------
    // Root error command, status and source identification
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            root_command_q <= aer_pkg::ROOT_COMMAND_RESET;
        end
        else if (cfg_write && cfg_addr == aer_pkg::ROOT_COMMAND_OFF)
        begin
            root_command_q <= cfg_wdata[2:0]; // RQ13
        end
    end

    always_comb
    begin
        root_set = 7'h00;
        root_clr = cfg_wdata[6:0] & {7{cfg_write && cfg_addr == aer_pkg::ROOT_STATUS_OFF}};
        root_set[aer_pkg::RS_FATAL] = msg_fatal; // RQ14
        root_set[aer_pkg::RS_NONFATAL] = msg_nonfatal; // RQ14
        root_set[aer_pkg::RS_FIRST_FATAL] = msg_fatal & ~root_status_q[aer_pkg::RS_UNCOR]; // RQ15
        root_set[aer_pkg::RS_UNCOR] =
            (msg_fatal | msg_nonfatal) & ~root_status_q[aer_pkg::RS_UNCOR]; // RQ16
        root_set[aer_pkg::RS_MULT_UNCOR] =
            (msg_fatal | msg_nonfatal) & root_status_q[aer_pkg::RS_UNCOR]; // RQ16
        root_set[aer_pkg::RS_COR] = msg_cor & ~root_status_q[aer_pkg::RS_COR]; // RQ17
        root_set[aer_pkg::RS_MULT_COR] = msg_cor & root_status_q[aer_pkg::RS_COR]; // RQ17
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            root_status_q <= aer_pkg::ROOT_STATUS_RESET;
        end
        else
        begin
            root_status_q <= (root_status_q & ~root_clr) | root_set; // RQ22
        end
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            uncorrectable_source_id_q <= 16'h0000;
            correctable_source_id_q <= 16'h0000;
        end
        else
        begin
            if ((msg_fatal || msg_nonfatal) && !root_status_q[aer_pkg::RS_UNCOR])
            begin
                uncorrectable_source_id_q <= msg_requester_id; // RQ18
            end
            if (msg_cor && !root_status_q[aer_pkg::RS_COR])
            begin
                correctable_source_id_q <= msg_requester_id; // RQ19
            end
        end
    end

    // ----------------------------------------------------------------
    // Reporting and interrupt
    // ----------------------------------------------------------------
    // Reports are one-cycle pulses one edge after the error; the interrupt
    // is a level that drops once software clears the causing status.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            report_fatal <= 1'b0;
            report_nonfatal <= 1'b0;
            report_correctable <= 1'b0;
            error_interrupt <= 1'b0;
        end
        else
        begin
            report_fatal <= |(uncor_new & uncor_sev_q); // RQ3
            report_nonfatal <= |(uncor_new & ~uncor_sev_q); // RQ1
            report_correctable <= |(cor_event & ~(cor_mask_q & aer_pkg::COR_RW_BITS)); // RQ9
            error_interrupt <= (root_command_q[2] & root_status_q[aer_pkg::RS_FATAL]) |
                (root_command_q[1] & root_status_q[aer_pkg::RS_NONFATAL]) |
                (root_command_q[0] & root_status_q[aer_pkg::RS_COR]); // RQ13
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            cfg_rdata <= 32'h00000000;
            cfg_rvalid <= 1'b0;
        end
        else
        begin
            cfg_rvalid <= cfg_read;
            if (cfg_read)
            begin
                case (cfg_addr)
                    aer_pkg::UNCOR_STATUS_OFF: cfg_rdata <= uncor_status_q;
                    aer_pkg::UNCOR_MASK_OFF: cfg_rdata <= uncor_mask_q;
                    aer_pkg::UNCOR_SEVERITY_OFF: cfg_rdata <= uncor_sev_q;
                    aer_pkg::COR_STATUS_OFF: cfg_rdata <= cor_status_q;
                    aer_pkg::COR_MASK_OFF: cfg_rdata <= cor_mask_q;
                    aer_pkg::ADV_CONTROL_OFF: cfg_rdata <= {27'h0, first_error_position_q}; // RQ10
                    aer_pkg::HEADER_LOG0_OFF: cfg_rdata <= logged_packet_header_q[127:96]; // RQ12
                    aer_pkg::HEADER_LOG1_OFF: cfg_rdata <= logged_packet_header_q[95:64];
                    aer_pkg::HEADER_LOG2_OFF: cfg_rdata <= logged_packet_header_q[63:32];
                    aer_pkg::HEADER_LOG3_OFF: cfg_rdata <= logged_packet_header_q[31:0];
                    aer_pkg::ROOT_COMMAND_OFF: cfg_rdata <= {29'h0, root_command_q};
                    aer_pkg::ROOT_STATUS_OFF:
                        cfg_rdata <= {aer_pkg::ERR_VECTOR_NUMBER, 20'h0, root_status_q}; // RQ20
                    aer_pkg::SOURCE_ID_OFF:
                        cfg_rdata <= {uncorrectable_source_id_q, correctable_source_id_q};
                    default: cfg_rdata <= 32'h00000000; // RQ22
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    mult_uncor_set_a: assert property ((msg_fatal || msg_nonfatal) && root_status_q[2]
        |=> root_status_q[3]) else $error("multiple uncorrectable not set"); // RQ16
    first_uncor_set_a: assert property ((msg_fatal || msg_nonfatal) && !root_status_q[2]
        |=> root_status_q[2]) else $error("uncorrectable received not set"); // RQ16
    mult_cor_set_a: assert property (msg_cor && root_status_q[0]
        && !(cfg_write && cfg_addr == aer_pkg::ROOT_STATUS_OFF && cfg_wdata[0])
        |=> root_status_q[1] && root_status_q[0]) else $error("multiple cor not set"); // RQ17
    first_fatal_flag_a: assert property (msg_fatal && !root_status_q[2]
        |=> root_status_q[4]) else $error("first fatal flag missing"); // RQ15
    uncor_src_hold_a: assert property (root_status_q[2]
        |=> $stable(uncorrectable_source_id_q)) else $error("source id overwritten"); // RQ18
    cor_src_load_a: assert property (msg_cor && !root_status_q[0]
        |=> correctable_source_id_q == $past(msg_requester_id))
        else $error("cor source id not loaded"); // RQ19
    advisory_set_a: assert property (unsupported_request_err && !uncor_sev_q[20]
        |=> cor_status_q[13]) else $error("advisory flag not set"); // RQ4
    link_crc_flags_a: assert property (link_crc_err
        |=> cor_status_q[7] && cor_status_q[6]) else $error("crc flags not set"); // RQ6
    malformed_log_a: assert property (malformed_packet_err && !uncor_mask_q[18]
        && !(|(uncor_status_q & ~uncor_mask_q)) && !uncor_new[20]
        |=> uncor_status_q[18] && first_error_position_q == 5'h12
        && logged_packet_header_q == $past(err_packet_header))
        else $error("malformed not logged"); // RQ21
    e2e_bit_fixed_a: assert property (##1 !uncor_mask_q[19] && !uncor_sev_q[19])
        else $error("crc bit changed while check disabled"); // RQ2
    w1c_clear_a: assert property (cfg_write && cfg_addr == aer_pkg::COR_STATUS_OFF && cfg_wdata[7]
        && !link_crc_err |=> !cor_status_q[7]) else $error("write one did not clear"); // RQ22
    intr_fatal_a: assert property (root_command_q[2] && root_status_q[6]
        |=> error_interrupt) else $error("fatal interrupt missing"); // RQ13

    fatal_msg_c: cover property (msg_fatal ##[1:20] msg_nonfatal);
    cor_twice_c: cover property (msg_cor ##[1:20] msg_cor);
    malformed_c: cover property (malformed_packet_err && report_nonfatal == 1'b0);

endmodule

// File: sim/aer_msg_model.sv
// Model of the downstream devices that send error messages to the root port.
// Assumes the bench calls send from one process at a time.
`timescale 1ns/1ps
module aer_msg_model (
    input wire logic clock,
    output logic msg_cor,
    output logic msg_nonfatal,
    output logic msg_fatal,
    output logic [15:0] msg_requester_id
);
    initial
    begin
        msg_cor = 1'b0;
        msg_nonfatal = 1'b0;
        msg_fatal = 1'b0;
        msg_requester_id = 16'hFFFF;
    end

    // Kind 0 is correctable, 1 non-fatal, 2 fatal; gap plus one falling edges pass first.
    task automatic send(input int kind, input logic [15:0] id, input int gap);
        repeat (gap + 1) @(negedge clock);
        msg_cor = (kind == 0);
        msg_nonfatal = (kind == 1);
        msg_fatal = (kind == 2);
        msg_requester_id = id;
        @(negedge clock);
        msg_cor = 1'b0;
        msg_nonfatal = 1'b0;
        msg_fatal = 1'b0;
        // The ID is no longer valid, so it must not look like the last one.
        msg_requester_id = ~id;
    endtask
endmodule

// File: sim/aer_regs_test.sv
// Self-checking bench for the root port error reporting registers.
// Assumes aer_pkg and the message model are compiled first.
`timescale 1ns/1ps
module aer_regs_test;
    logic clock;
    logic rst;
    logic cfg_write;
    logic cfg_read;
    logic [11:0] cfg_addr;
    logic [31:0] cfg_wdata;
    logic [31:0] cfg_rdata;
    logic cfg_rvalid;
    logic [10:0] ev;
    logic [127:0] hdr;
    logic m_cor;
    logic m_nf;
    logic m_f;
    logic [15:0] rid;
    logic rep_f;
    logic rep_nf;
    logic rep_c;
    logic irq;
    int mismatches;
    int n_compared;

    aer_regs aer_regs_inst (.clock(clock), .rst(rst), .cfg_write(cfg_write),
        .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
        .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
        .unsupported_request_err(ev[0]), .malformed_packet_err(ev[1]),
        .unexpected_completion_err(ev[2]), .completion_timeout_err(ev[3]),
        .poisoned_packet_err(ev[4]), .link_protocol_err(ev[5]),
        .err_packet_header(hdr), .replay_timeout_err(ev[6]), .replay_rollover_err(ev[7]),
        .link_crc_err(ev[8]), .bad_sequence_err(ev[9]), .receiver_decode_err(ev[10]),
        .msg_cor(m_cor), .msg_nonfatal(m_nf), .msg_fatal(m_f), .msg_requester_id(rid),
        .report_fatal(rep_f), .report_nonfatal(rep_nf), .report_correctable(rep_c),
        .error_interrupt(irq));
    aer_msg_model aer_msg_model_inst (.clock(clock), .msg_cor(m_cor), .msg_nonfatal(m_nf),
        .msg_fatal(m_f), .msg_requester_id(rid));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(negedge clock);
        cfg_write = 1'b1;
        cfg_addr = a;
        cfg_wdata = d;
        @(negedge clock);
        cfg_write = 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(negedge clock);
        cfg_read = 1'b1;
        cfg_addr = a;
        @(negedge clock);
        cfg_read = 1'b0;
        chk("rvalid", 32'h1, {31'h0, cfg_rvalid});
        chk(what, exp, cfg_rdata);
    endtask
    // Report pulses are checked at the negedge that follows the taking edge.
    task automatic pulse(input int i);
        @(negedge clock);
        ev[i] = 1'b1;
        @(negedge clock);
        ev[i] = 1'b0;
    endtask
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset;
        rd(aer_pkg::UNCOR_SEVERITY_OFF, 32'h00062030, "severity");
        rd(aer_pkg::COR_MASK_OFF, 32'h00002000, "cor mask");
        rd(aer_pkg::ADV_CONTROL_OFF, 32'h0, "control");
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h0, "root status");
        rd(12'h100, 32'h0, "unmapped");
        $display("reset values done");
    endtask
    task automatic t_access;
        wr(aer_pkg::UNCOR_MASK_OFF, 32'hFFFFFFFF);
        rd(aer_pkg::UNCOR_MASK_OFF, 32'h00155010, "uncor mask");
        wr(aer_pkg::UNCOR_SEVERITY_OFF, 32'hFFFFFFFF);
        rd(aer_pkg::UNCOR_SEVERITY_OFF, 32'h00177030, "severity");
        wr(aer_pkg::COR_MASK_OFF, 32'hFFFFFFFF);
        rd(aer_pkg::COR_MASK_OFF, 32'h000031C0, "cor mask");
        wr(aer_pkg::UNCOR_MASK_OFF, 32'h0);
        wr(aer_pkg::UNCOR_SEVERITY_OFF, 32'h0);
        wr(aer_pkg::ROOT_COMMAND_OFF, 32'hFFFFFFFF);
        rd(aer_pkg::ROOT_COMMAND_OFF, 32'h7, "command");
        $display("access kinds done");
    endtask
    task automatic t_uncor;
        pulse(1);
        chk("nonfatal report", 32'h1, {31'h0, rep_nf});
        rd(aer_pkg::UNCOR_STATUS_OFF, 32'h00040000, "uncor status");
        rd(aer_pkg::ADV_CONTROL_OFF, 32'h12, "first error");
        for (int i = 0; i < 4; i++)
            rd(aer_pkg::HEADER_LOG0_OFF + 12'(4 * i), hdr[127 - 32 * i -: 32], "log");
        wr(aer_pkg::UNCOR_STATUS_OFF, 32'h00040000);
        rd(aer_pkg::UNCOR_STATUS_OFF, 32'h0, "uncor status");
        wr(aer_pkg::UNCOR_MASK_OFF, 32'h00100000);
        pulse(0);
        chk("masked report", 32'h0, {31'h0, rep_nf | rep_f});
        wr(aer_pkg::UNCOR_MASK_OFF, 32'h0);
        wr(aer_pkg::UNCOR_SEVERITY_OFF, 32'h00010000);
        pulse(2);
        chk("fatal report", 32'h1, {31'h0, rep_f});
        for (int i = 3; i < 6; i++)
        begin
            pulse(i);
            chk("nonfatal report", 32'h1, {31'h0, rep_nf});
        end
        $display("uncorrectable done");
    endtask
    task automatic t_cor;
        wr(aer_pkg::UNCOR_SEVERITY_OFF, 32'h0);
        wr(aer_pkg::COR_STATUS_OFF, 32'hFFFFFFFF);
        pulse(8);
        chk("masked cor report", 32'h0, {31'h0, rep_c});
        rd(aer_pkg::COR_STATUS_OFF, 32'h000000C0, "cor status");
        wr(aer_pkg::COR_STATUS_OFF, 32'h00000040);
        rd(aer_pkg::COR_STATUS_OFF, 32'h00000080, "cor status");
        pulse(6);
        pulse(7);
        pulse(9);
        pulse(10);
        chk("cor report", 32'h1, {31'h0, rep_c});
        pulse(0);
        rd(aer_pkg::COR_STATUS_OFF, 32'h000031C1, "cor status");
        wr(aer_pkg::COR_STATUS_OFF, 32'hFFFFFFFF);
        rd(aer_pkg::COR_STATUS_OFF, 32'h00000001, "cor status");
        $display("correctable done");
    endtask
    task automatic t_msg;
        aer_msg_model_inst.send(0, 16'h1111, 0);
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h1, "root status");
        chk("interrupt", 32'h1, {31'h0, irq});
        aer_msg_model_inst.send(0, 16'h2222, 3);
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h3, "root status");
        aer_msg_model_inst.send(2, 16'h3333, 0);
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h57, "root status");
        aer_msg_model_inst.send(1, 16'h4444, 1);
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h7F, "root status");
        rd(aer_pkg::SOURCE_ID_OFF, 32'h33331111, "source id");
        wr(aer_pkg::ROOT_STATUS_OFF, 32'h7F);
        rd(aer_pkg::ROOT_STATUS_OFF, 32'h0, "root status");
        $display("messages done");
    endtask

    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial
    begin
        #50000;
        mismatches++;
        results();
    end
    initial
    begin
        rst = 1'b1;
        cfg_write = 1'b0;
        cfg_read = 1'b0;
        cfg_addr = 12'h000;
        cfg_wdata = 32'h0;
        ev = 11'h000;
        hdr = 128'h00112233_44556677_8899AABB_CCDDEEFF;
        mismatches = 0;
        n_compared = 0;
        repeat (3) @(negedge clock);
        rst = 1'b0;
        t_reset();
        t_access();
        t_uncor();
        t_cor();
        t_msg();
        results();
    end
endmodule
